// *** src/bmil_pkg.sv ***
// package for the byte mask / inversion lane: mode bit positions, slot counts,
// link timing and the zero-count function shared by both ends.
// assumes one 50 MHz clock on each end and a controller-made link clock.
package bmil_pkg;
   // ----------------------------------------------------------------
   // mode word layout
   // ----------------------------------------------------------------
   localparam int MODE_W        = 14;
   localparam int ONE_TERM_BIT  = 11;
   localparam int FIVE_RINV_BIT = 12;
   localparam int FIVE_WINV_BIT = 11;
   localparam int FIVE_MASK_BIT = 10;
   // ----------------------------------------------------------------
   // organisation codes and burst shape
   // ----------------------------------------------------------------
   localparam int ORG_X4        = 0;
   localparam int ORG_X8        = 1;
   localparam int ORG_X16       = 2;
   localparam int LANES         = 2;
   localparam int BURST_LEN     = 8;
   localparam int ZERO_LIMIT    = 4;
   // ----------------------------------------------------------------
   // link timing
   // ----------------------------------------------------------------
   localparam int MCLK_NS       = 20;
   localparam int LINK_PERIOD_NS = 160;
   localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * MCLK_NS);
   // host samples read slot n at link rise n+RD_FIRST_RISE after the command slot
   localparam int RD_FIRST_RISE = 2;
   localparam int RD_LAST_RISE  = RD_FIRST_RISE + BURST_LEN - 1;
   localparam logic [3:0] SLOT_END = 4'h8;

   // true when the byte holds more than ZERO_LIMIT zero bits
   function automatic logic bmil_zero_heavy(input logic [7:0] b);
      int zeros;
      zeros = 0;
      for (int i = 0; i < 8; i++) begin
         if (!b[i]) zeros++;
      end
      return zeros > ZERO_LIMIT;
   endfunction
endpackage

// *** src/bmil_link_if.sv ***
// link between controller end and device end: data lanes, shared flag pins,
// frame strobes and link clock. data and flag wires idle high (termination to the rail).
`timescale 1ns/10ps
`default_nettype none
interface bmil_link_if;
   logic        link_clk;
   logic        wr_frame;
   logic        rd_go;
   logic [15:0] dq_h_o;
   logic [1:0]  dq_h_oe;
   logic [15:0] dq_d_o;
   logic [1:0]  dq_d_oe;
   logic [1:0]  flag_h_o;
   logic [1:0]  flag_h_oe;
   logic [1:0]  flag_d_o;
   logic [1:0]  flag_d_oe;
   logic [15:0] dq;
   logic [1:0]  flag;

   // resolved wire level; undriven lanes pull high
   always_comb begin
      for (int l = 0; l < 2; l++) begin
         dq[8*l +: 8] = dq_d_oe[l] ? dq_d_o[8*l +: 8] :
                        dq_h_oe[l] ? dq_h_o[8*l +: 8] : 8'hff;
         flag[l] = flag_d_oe[l] ? flag_d_o[l] : flag_h_oe[l] ? flag_h_o[l] : 1'b1;
      end
   end

   modport host (output link_clk, wr_frame, rd_go, dq_h_o, dq_h_oe, flag_h_o,
                 flag_h_oe, input dq, flag);
   modport dev  (input link_clk, wr_frame, rd_go, dq, flag,
                 output dq_d_o, dq_d_oe, flag_d_o, flag_d_oe);
endinterface
`default_nettype wire

// *** src/bmil_skid.sv ***
// two-entry buffer with valid/ready on both sides.
// assumes source and sink on the same clock.
`timescale 1ns/10ps
`default_nettype none
module bmil_skid #(
   parameter int W     = 18,
   parameter int DEPTH = 2
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         reset_n,
   // fill side
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // drain side
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wptr, next_wptr, rptr, next_rptr;
   logic [AW:0]   count, next_count;
   logic          push, pop;

   always_comb begin
      push       = in_valid && in_ready;
      pop        = out_valid && out_ready;
      next_wptr  = push ? AW'((wptr + 1'b1) % DEPTH) : wptr;
      next_rptr  = pop ? AW'((rptr + 1'b1) % DEPTH) : rptr;
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         wptr  <= '0;
         rptr  <= '0;
         count <= '0;
      end else begin
         wptr  <= next_wptr;
         rptr  <= next_rptr;
         count <= next_count;
      end
      if (push) mem[wptr] <= in_data;
   end

   assign in_ready  = count != (AW+1)'(DEPTH);
   assign out_valid = count != '0;
   assign out_data  = mem[rptr];
endmodule // bmil_skid
`default_nettype wire

// *** src/bmil_dev.sv ***
// device end of the byte lane: write mask / write inversion decode, read
// inversion encode and termination strobe control on the shared flag pin.
// assumes the link clock comes from the controller; all pins are synchronised.
// Operation
// - mask and inversion only in x8, x16
// - termination strobe only in x8
// - one shared active-low pin per lane
// - termination strobe never drives the pin
// - mode bits: one A11, five A12..A10
// - controller never enables mask and inversion together
// - both write functions off: ignore pin
// - read inversion off: pin driver off
// - termination strobe disables mask and inversion
// - strobe termination matches data strobe termination
// - mask low drops byte, high writes
// - inversion low inverts byte, high keeps
// - over four zeros: invert, flag low
// - x8 burst: eight bytes, flag per slot
// - x16: each lane paired with own pin
// - read pin carries only inversion flag
`timescale 1ns/10ps
`default_nettype none
module bmil_dev
   import bmil_pkg::*;
#(
   parameter int ORG = ORG_X8
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              reset_n,
   // mode words
   input  wire logic [MODE_W-1:0] mode_word_one,
   input  wire logic [MODE_W-1:0] mode_word_five,
   input  wire logic              dqs_rtt_en,
   output logic                   term_rtt_on,
   // received write bytes
   output logic                   wr_valid,
   output logic [15:0]            wr_data,
   output logic [1:0]             wr_keep,
   input  wire logic              wr_ready,
   output logic                   wr_overrun,
   // read bytes to send
   input  wire logic [15:0]       rd_word,
   output logic                   rd_next,
   // link
   bmil_link_if.dev               link
);
   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   logic       has_flags, term_en, mask_en, wdbi_en, rdbi_en, rx_on;
   logic [1:0] lane_on;

   always_comb begin
      has_flags = ORG != ORG_X4;
      term_en   = (ORG == ORG_X8) && mode_word_one[ONE_TERM_BIT];
      mask_en   = has_flags && !term_en && mode_word_five[FIVE_MASK_BIT];
      // mask wins if both are set by mistake
      wdbi_en   = has_flags && !term_en && !mask_en
                  && mode_word_five[FIVE_WINV_BIT];
      rdbi_en   = has_flags && !term_en && mode_word_five[FIVE_RINV_BIT];
      rx_on     = mask_en || wdbi_en;
      lane_on   = (ORG == ORG_X16) ? 2'b11 : 2'b01;
   end

   // ----------------------------------------------------------------
   // pin synchroniser
   // ----------------------------------------------------------------
   // dq and flag share one stage pair so a byte never slips against its flag
   localparam int SW = 21;
   logic [SW-1:0] sync1, sync2;
   logic          clk_d;
   logic          clk_s, frame_s, go_s, rise;
   logic [15:0]   dq_s;
   logic [1:0]    flag_s;

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         sync1 <= {SW{1'b1}};
         sync2 <= {SW{1'b1}};
         clk_d <= 1'b1;
      end else begin
         sync1 <= {link.link_clk, link.wr_frame, link.rd_go, link.dq, link.flag};
         sync2 <= sync1;
         clk_d <= clk_s;
      end
   end

   assign {clk_s, frame_s, go_s, dq_s, flag_s} = sync2;
   assign rise = clk_s && !clk_d;

   // ----------------------------------------------------------------
   // write slot decode
   // ----------------------------------------------------------------
   logic        push, push_ready;
   logic [15:0] push_data;
   logic [1:0]  push_keep;
   logic        fl;
   logic [7:0]  b;

   always_comb begin
      push_data = '0;
      push_keep = '0;
      fl        = 1'b1;
      b         = '0;
      for (int l = 0; l < LANES; l++) begin
         b  = dq_s[8*l +: 8];
         fl = rx_on ? flag_s[l] : 1'b1;
         push_data[8*l +: 8] = (wdbi_en && !fl) ? ~b : b;
         push_keep[l] = lane_on[l] && !(mask_en && !fl);
      end
   end

   // ----------------------------------------------------------------
   // burst control
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {D_IDLE, D_READ} bmil_dstate_t;
   bmil_dstate_t state, next_state;
   logic [3:0]   slot, next_slot;
   logic [15:0]  dq_o, next_dq_o;
   logic [1:0]   dq_oe, next_dq_oe;
   logic [1:0]   fl_o, next_fl_o;
   logic [1:0]   fl_oe, next_fl_oe;
   logic         next_rd_next, overrun, next_overrun, next_term;
   logic         inv;

   assign push = rise && frame_s && (state == D_IDLE);

   always_comb begin
      next_state   = state;
      next_slot    = slot;
      next_dq_o    = dq_o;
      next_dq_oe   = dq_oe;
      next_fl_o    = fl_o;
      next_fl_oe   = fl_oe;
      next_rd_next = 1'b0;
      next_overrun = overrun || (push && !push_ready);
      next_term    = term_en && dqs_rtt_en;
      inv          = 1'b0;
      case (state)
         D_IDLE: begin
            if (rise && go_s && !frame_s) begin
               next_state = D_READ;
               next_slot  = '0;
            end
         end
         D_READ: begin
            if (rise) begin
               if (slot == SLOT_END) begin
                  next_state = D_IDLE;
                  next_dq_oe = '0;
                  next_fl_oe = '0;
               end else begin
                  next_rd_next = 1'b1;
                  next_slot    = slot + 4'h1;
                  next_dq_oe   = lane_on;
                  for (int l = 0; l < LANES; l++) begin
                     inv = rdbi_en && bmil_zero_heavy(rd_word[8*l +: 8]);
                     next_dq_o[8*l +: 8] = inv ? ~rd_word[8*l +: 8]
                                               : rd_word[8*l +: 8];
                     next_fl_o[l]  = !inv;
                     // no driver when read inversion is off or strobe mode
                     next_fl_oe[l] = rdbi_en && lane_on[l];
                  end
               end
            end
         end
         default: next_state = D_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state       <= D_IDLE;
         slot        <= '0;
         dq_o        <= '0;
         dq_oe       <= '0;
         fl_o        <= '1;
         fl_oe       <= '0;
         rd_next     <= 1'b0;
         overrun     <= 1'b0;
         term_rtt_on <= 1'b0;
      end else begin
         state       <= next_state;
         slot        <= next_slot;
         dq_o        <= next_dq_o;
         dq_oe       <= next_dq_oe;
         fl_o        <= next_fl_o;
         fl_oe       <= next_fl_oe;
         rd_next     <= next_rd_next;
         overrun     <= next_overrun;
         term_rtt_on <= next_term;
      end
   end

   assign link.dq_d_o    = dq_o;
   assign link.dq_d_oe   = dq_oe;
   assign link.flag_d_o  = fl_o;
   assign link.flag_d_oe = fl_oe;
   assign wr_overrun     = overrun;

   // ----------------------------------------------------------------
   // write buffer
   // ----------------------------------------------------------------
   // a full buffer cannot stall the link; the lost byte raises overrun
   bmil_skid #(.W(18), .DEPTH(2)) u_buf (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .in_valid  (push),
      .in_data   ({push_keep, push_data}),
      .in_ready  (push_ready),
      .out_valid (wr_valid),
      .out_data  ({wr_keep, wr_data}),
      .out_ready (wr_ready)
   );
endmodule // bmil_dev
`default_nettype wire

// *** src/bmil_host.sv ***
// controller end: makes the link clock, sends write bursts with mask or
// inversion flags and receives read bursts, undoing read inversion.
// assumes the device answers a read command one link slot later.
`timescale 1ns/10ps
`default_nettype none
module bmil_host
   import bmil_pkg::*;
#(
   parameter int ORG  = ORG_X8,
   parameter int HALF = LINK_HALF_CYC
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              reset_n,
   // mode words
   input  wire logic [MODE_W-1:0] mode_word_one,
   input  wire logic [MODE_W-1:0] mode_word_five,
   // requests
   input  wire logic              start_wr,
   input  wire logic              start_rd,
   output logic                   busy,
   // write bytes
   input  wire logic [15:0]       wr_word,
   input  wire logic [1:0]        wr_mask_n,
   output logic                   wr_next,
   // read bytes
   output logic                   rd_valid,
   output logic [15:0]            rd_word,
   // link
   bmil_link_if.host              link
);
   // ----------------------------------------------------------------
   // mode decode and pin sync
   // ----------------------------------------------------------------
   logic       term_en, mask_en, wdbi_en, rdbi_en;
   logic [1:0] lane_on;
   logic [17:0] s1, s2;
   logic [15:0] dq_s;
   logic [1:0]  fl_s;

   always_comb begin
      term_en = (ORG == ORG_X8) && mode_word_one[ONE_TERM_BIT];
      mask_en = ORG != ORG_X4 && !term_en && mode_word_five[FIVE_MASK_BIT];
      wdbi_en = ORG != ORG_X4 && !term_en && !mask_en && mode_word_five[FIVE_WINV_BIT];
      rdbi_en = ORG != ORG_X4 && !term_en && mode_word_five[FIVE_RINV_BIT];
      lane_on = (ORG == ORG_X16) ? 2'b11 : 2'b01;
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         s1 <= '1;
         s2 <= '1;
      end else begin
         s1 <= {link.dq, link.flag};
         s2 <= s1;
      end
   end
   assign {dq_s, fl_s} = s2;

   // ----------------------------------------------------------------
   // link clock, burst control
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {H_IDLE, H_WR, H_RD} bmil_hstate_t;
   bmil_hstate_t state, next_state;
   logic [7:0]  div, next_div;
   logic        lclk, next_lclk, rise, fall;
   logic        wr_pend, next_wr_pend, rd_pend, next_rd_pend;
   logic [3:0]  cnt, next_cnt;
   logic        frame, next_frame, go, next_go;
   logic [15:0] dq_o, next_dq_o;
   logic [1:0]  dq_oe, next_dq_oe, fl_o, next_fl_o, fl_oe, next_fl_oe;
   logic        next_wr_next, next_rd_valid, inv;
   logic [15:0] next_rd_word;

   always_comb begin
      fall          = (div == 8'(HALF - 1)) && lclk;
      rise          = (div == 8'(HALF - 1)) && !lclk;
      next_div      = (div == 8'(HALF - 1)) ? 8'h00 : div + 8'h01;
      next_lclk     = (div == 8'(HALF - 1)) ? !lclk : lclk;
      next_wr_pend  = wr_pend || (start_wr && state == H_IDLE && !rd_pend);
      next_rd_pend  = rd_pend || (start_rd && state == H_IDLE && !wr_pend && !start_wr);
      next_state    = state;
      next_cnt      = cnt;
      next_frame    = frame;
      next_go       = go;
      next_dq_o     = dq_o;
      next_dq_oe    = dq_oe;
      next_fl_o     = fl_o;
      next_fl_oe    = fl_oe;
      next_wr_next  = 1'b0;
      next_rd_valid = 1'b0;
      next_rd_word  = rd_word;
      inv           = 1'b0;
      case (state)
         H_IDLE: begin
            if (fall && wr_pend) begin
               next_state   = H_WR;
               next_cnt     = '0;
               next_wr_pend = 1'b0;
            end else if (fall && rd_pend) begin
               next_state   = H_RD;
               next_cnt     = '0;
               next_go      = 1'b1;
               next_rd_pend = 1'b0;
            end
         end
         H_WR: begin
            if (fall) begin
               if (cnt == SLOT_END) begin
                  next_state = H_IDLE;
                  next_frame = 1'b0;
                  next_dq_oe = '0;
                  next_fl_oe = '0;
               end else begin
                  next_frame   = 1'b1;
                  next_wr_next = 1'b1;
                  next_cnt     = cnt + 4'h1;
                  next_dq_oe   = lane_on;
                  for (int l = 0; l < LANES; l++) begin
                     inv = wdbi_en && bmil_zero_heavy(wr_word[8*l +: 8]);
                     next_dq_o[8*l +: 8] = inv ? ~wr_word[8*l +: 8] : wr_word[8*l +: 8];
                     next_fl_o[l]  = mask_en ? wr_mask_n[l] : !inv;
                     next_fl_oe[l] = (mask_en || wdbi_en) && lane_on[l];
                  end
               end
            end
         end
         H_RD: begin
            if (fall) next_go = 1'b0;
            if (rise) begin
               next_cnt = cnt + 4'h1;
               if (cnt >= 4'(RD_FIRST_RISE)) begin
                  next_rd_valid = 1'b1;
                  for (int l = 0; l < LANES; l++) begin
                     next_rd_word[8*l +: 8] = (rdbi_en && !fl_s[l]) ? ~dq_s[8*l +: 8]
                                                                   : dq_s[8*l +: 8];
                  end
                  if (cnt == 4'(RD_LAST_RISE)) next_state = H_IDLE;
               end
            end
         end
         default: next_state = H_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         state    <= H_IDLE;
         div      <= '0;
         lclk     <= 1'b0;
         wr_pend  <= 1'b0;
         rd_pend  <= 1'b0;
         cnt      <= '0;
         frame    <= 1'b0;
         go       <= 1'b0;
         dq_o     <= '0;
         dq_oe    <= '0;
         fl_o     <= '1;
         fl_oe    <= '0;
         wr_next  <= 1'b0;
         rd_valid <= 1'b0;
         rd_word  <= '0;
         busy     <= 1'b0;
      end else begin
         state    <= next_state;
         div      <= next_div;
         lclk     <= next_lclk;
         wr_pend  <= next_wr_pend;
         rd_pend  <= next_rd_pend;
         cnt      <= next_cnt;
         frame    <= next_frame;
         go       <= next_go;
         dq_o     <= next_dq_o;
         dq_oe    <= next_dq_oe;
         fl_o     <= next_fl_o;
         fl_oe    <= next_fl_oe;
         wr_next  <= next_wr_next;
         rd_valid <= next_rd_valid;
         rd_word  <= next_rd_word;
         busy     <= next_wr_pend || next_rd_pend || next_state != H_IDLE;
      end
   end

   assign link.link_clk  = lclk;
   assign link.wr_frame  = frame;
   assign link.rd_go     = go;
   assign link.dq_h_o    = dq_o;
   assign link.dq_h_oe   = dq_oe;
   assign link.flag_h_o  = fl_o;
   assign link.flag_h_oe = fl_oe;
endmodule // bmil_host
`default_nettype wire

// *** tb/bmil_assertions.sv ***
// checker for the byte lane link: watches both ends' drives and the write frame strobe.
// assumes x16 ends on one mclk, instantiated beside the link interface.
`timescale 1ns/10ps
`default_nettype none
module bmil_assertions
   import bmil_pkg::*;
(
   // clock and reset
   input wire logic              mclk,
   input wire logic              reset_n,
   // mode
   input wire logic [MODE_W-1:0] mode_word_five,
   // link
   input wire logic              link_clk,
   input wire logic              wr_frame,
   input wire logic [1:0]        dq_h_oe,
   input wire logic [15:0]       dq_d_o,
   input wire logic [1:0]        dq_d_oe,
   input wire logic [1:0]        flag_h_oe,
   input wire logic [1:0]        flag_d_o,
   input wire logic [1:0]        flag_d_oe
);
   // ----------------------------------------------------------------
   // link rises seen while a frame or a read burst is on the wires
   // ----------------------------------------------------------------
   logic       link_q;
   logic [3:0] frame_rises;
   logic [3:0] rd_rises;
   logic [3:0] next_frame_rises;
   logic [3:0] next_rd_rises;
   always_comb begin
      next_frame_rises = !wr_frame ? 4'h0 : frame_rises + 4'(link_clk & !link_q);
      next_rd_rises    = !dq_d_oe[0] ? 4'h0 : rd_rises + 4'(link_clk & !link_q);
   end
   always_ff @(posedge mclk) begin
      link_q      <= reset_n & link_clk;
      frame_rises <= reset_n ? next_frame_rises : 4'h0;
      rd_rises    <= reset_n ? next_rd_rises : 4'h0;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   a_no_bus_fight: assert property ((dq_d_oe & dq_h_oe) == 2'h0)
      else $error("both ends drive one data lane");
   a_rd_flag_off: assert property (!mode_word_five[FIVE_RINV_BIT] |-> flag_d_oe == 2'h0)
      else $error("flag driven with read inversion off");
   a_flag_with_data: assert property ((flag_d_oe & ~dq_d_oe) == 2'h0)
      else $error("flag driven outside a read slot");
   a_rd_code_low: assert property (flag_d_oe[0] |->
      $countones(dq_d_o[7:0]) >= (flag_d_o[0] ? 4 : 5)) else $error("lower read code wrong");
   a_rd_code_high: assert property (flag_d_oe[1] |->
      $countones(dq_d_o[15:8]) >= (flag_d_o[1] ? 4 : 5)) else $error("upper read code wrong");
   a_frame_slots: assert property ($fell(wr_frame) |-> frame_rises == 4'h8)
      else $error("write frame not eight slots");
   a_rd_slots: assert property ($fell(dq_d_oe[0]) |-> rd_rises == 4'h8)
      else $error("read burst not eight slots");
   a_lanes_paired: assert property (dq_d_oe[1] == dq_d_oe[0] && flag_d_oe[1] == flag_d_oe[0])
      else $error("lanes out of step");
   a_host_flag_frame: assert property (flag_h_oe != 2'h0 |-> wr_frame)
      else $error("host flag outside frame");
endmodule // bmil_assertions
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench: x16 host and device ends joined by the link, queue models.
// assumes 50 MHz mclk and the host's default link divider.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top
   import bmil_pkg::*;
;
   logic              mclk = 1'b0;
   logic              reset_n = 1'b0;
   logic [MODE_W-1:0] mw1 = '0;
   logic [MODE_W-1:0] mw5 = '0;
   logic              start_wr = 1'b0;
   logic              start_rd = 1'b0;
   logic              wr_ready = 1'b1;
   logic              dqs_rtt_en = 1'b1;
   logic [15:0]       wr_word = 16'h5a3c;
   logic [15:0]       d_rd_word = 16'h0007;
   logic [1:0]        wr_mask_n = 2'h2;
   logic              busy, wr_next, rd_valid, wr_valid, wr_overrun, rd_next, term_rtt_on;
   logic [15:0]       h_rd_word, wr_data, rx, m;
   logic [1:0]        wr_keep, k;
   logic [17:0]       e;
   logic [31:0]       seed = 32'h1d;
   logic [31:0]       r;
   logic              nw = 1'b0;
   logic              nr = 1'b0;
   logic              stall = 1'b0;
   int                num_errors = 0;
   int                total_checks = 0;
   int                delivered = 0;
   logic [17:0]       wq[$];
   logic [15:0]       rq[$];
   // read inversion, write inversion, mask per test; the last test sets the strobe bit
   logic [2:0]        modes [5] = '{3'h5, 3'h6, 3'h0, 3'h1, 3'h0};

   bmil_link_if link_inst ();
   bmil_host #(.ORG(ORG_X16)) bmil_host_inst (.mclk(mclk), .reset_n(reset_n),
      .mode_word_one(mw1), .mode_word_five(mw5), .start_wr(start_wr), .start_rd(start_rd),
      .busy(busy), .wr_word(wr_word), .wr_mask_n(wr_mask_n), .wr_next(wr_next),
      .rd_valid(rd_valid), .rd_word(h_rd_word), .link(link_inst));
   bmil_dev #(.ORG(ORG_X16)) bmil_dev_inst (.mclk(mclk), .reset_n(reset_n),
      .mode_word_one(mw1), .mode_word_five(mw5), .dqs_rtt_en(dqs_rtt_en),
      .term_rtt_on(term_rtt_on), .wr_valid(wr_valid), .wr_data(wr_data), .wr_keep(wr_keep),
      .wr_ready(wr_ready), .wr_overrun(wr_overrun), .rd_word(d_rd_word), .rd_next(rd_next),
      .link(link_inst));
   bmil_assertions chk_inst (.mclk(mclk), .reset_n(reset_n), .mode_word_five(mw5),
      .link_clk(link_inst.link_clk), .wr_frame(link_inst.wr_frame),
      .dq_h_oe(link_inst.dq_h_oe), .dq_d_o(link_inst.dq_d_o), .dq_d_oe(link_inst.dq_d_oe),
      .flag_h_oe(link_inst.flag_h_oe), .flag_d_o(link_inst.flag_d_o),
      .flag_d_oe(link_inst.flag_d_oe));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic burst(input bit rd);
      int n;
      n = 0;
      @(posedge mclk);
      if (rd) start_rd <= 1'b1;
      else start_wr <= 1'b1;
      @(posedge mclk);
      start_rd <= 1'b0;
      start_wr <= 1'b0;
      // busy only shows from the edge after the take
      @(posedge mclk);
      while (busy !== 1'b0 && n < 400) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 400) `CHK(n, 0)
      // let the buffer and the read decode drain
      repeat (40) @(posedge mclk);
   endtask

   always #10 mclk = ~mclk;

   // ----------------------------------------------------------------
   // stimulus: new words after each take, sink stalls a quarter of cycles, every cycle while stall is set
   // ----------------------------------------------------------------
   always @(posedge mclk) begin
      r = xs();
      wr_ready <= stall ? 1'b0 : (r[1:0] != 2'h0);
      if (nw) begin
         wr_word <= r[31:16];
         wr_mask_n <= r[3:2];
         nw = 1'b0;
      end
      if (nr) begin
         d_rd_word <= r[4] ? r[20:5] : {r[5] ? 8'h00 : 8'h0f, r[6] ? 8'h07 : 8'hf0};
         nr = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // model: sampled mid-cycle, where every output has settled
   // ----------------------------------------------------------------
   always @(negedge mclk) begin
      if (wr_next === 1'b1) begin
         wq.push_back({wr_mask_n, wr_word});
         nw = 1'b1;
      end
      if (rd_next === 1'b1) begin
         rq.push_back(d_rd_word);
         nr = 1'b1;
      end
      if (wr_valid === 1'b1 && wr_ready) begin
         e = (wq.size() > 0) ? wq.pop_front() : 18'h0;
         k = mw5[FIVE_MASK_BIT] ? e[17:16] : 2'h3;
         m = {{8{k[1]}}, {8{k[0]}}};
         `CHK(wr_keep, k);
         `CHK(wr_data & m, e[15:0] & m);
         delivered++;
      end
      if (rd_valid === 1'b1) begin
         rx = (rq.size() > 0) ? rq.pop_front() : 16'h0;
         `CHK(h_rd_word, rx);
      end
   end

   initial begin
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      for (int t = 0; t < 5; t++) begin
         mw5 <= 14'(modes[t]) << FIVE_MASK_BIT;
         mw1 <= (t == 4) ? 14'h0800 : 14'h0000;
         repeat (2) @(posedge mclk);
         burst(1'b0);
         burst(1'b1);
         `CHK(term_rtt_on, 1'b0);
         `CHK(wr_overrun, 1'b0);
         $display("test %0d done", t);
      end
      mw1 <= 14'h0000;
      stall = 1'b1;
      delivered = 0;
      burst(1'b0);
      `CHK(wr_overrun, 1'b1);
      stall = 1'b0;
      repeat (20) @(posedge mclk);
      `CHK(delivered, 2);
      wq.delete();
      reset_n <= 1'b0;
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      @(negedge mclk);
      `CHK(wr_overrun, 1'b0);
      $display("test stall done");
      stop_test();
   end

   initial begin
      #200us;
      num_errors++;
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
